//--- camis_far.sv
// camis_far: far-side model that feeds the register block with
// acceptance queries, buffer completions and error status.
// assumes the bench calls its tasks just after rising edges of clk_sys.
`timescale 1ns/10ps
module camis_far (
  // clock
  input wire logic clk_sys,
  // towards the register block
  output camis_pkg::camis_accept_type acc_o,
  output logic [14:0] done_o,
  output camis_pkg::camis_err_type err_o
);
  // idle levels at time zero
  initial begin
    acc_o = '0;
    done_o = '0;
    err_o = '0;
  end
  // one-cycle query; afterwards the data lines show inverted junk
  task automatic query(input logic b14, input logic [31:0] rx, held);
    @(posedge clk_sys);
    acc_o <= {1'b1, b14, rx, held};
    @(posedge clk_sys);
    acc_o <= {1'b0, ~b14, ~rx, ~held};
  endtask
  // completion lines, bit n for buffer n, held until set again
  task automatic setd(input logic [14:0] m);
    done_o <= m;
  endtask
  // error event: pulses last one cycle, state and counters stay
  task automatic err(input logic be, ci, input logic [2:0] ns,
    input logic [7:0] rec, tec);
    @(posedge clk_sys);
    err_o <= {be, ci, ns, rec, tec};
    @(posedge clk_sys);
    err_o.bus_error <= 1'b0;
    err_o.cnt_inc <= 1'b0;
  endtask
endmodule

//--- camis_pkg.sv
// camis_pkg: register map, field layout and carriers for the
// acceptance-mask, interrupt-status and error-counter register block.
// assumes a 16-bit register view carried on a 32-bit wishbone data bus.
package camis_pkg;

  // byte offsets of the word-aligned registers
  localparam logic [7:0] OFF_GMASK_HI = 8'h00;
  localparam logic [7:0] OFF_GMASK_LO = 8'h04;
  localparam logic [7:0] OFF_BMASK_HI = 8'h08;
  localparam logic [7:0] OFF_BMASK_LO = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_IRQ_PEND = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_CODE_EN = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_ERR_CNT = 8'h24;
  localparam logic [7:0] OFF_ERR_CFG = 8'h28;

  // reset values
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] RST_IRQ = 16'h0000;
  localparam logic RST_ERR_TYPE = 1'b0;

  // field positions in the 16-bit interrupt registers
  localparam int ERR_BIT = 15;
  localparam int NUM_BUF = 15;
  localparam int BUF14 = 14;
  // status register fields
  localparam int ST_REQ_BIT = 4;
  localparam int ST_NS_LSB = 5;
  // error config register field
  localparam int CFG_TYPE_BIT = 0;

  // identifier bits that standard frames use: high word bits 15..3
  localparam logic [31:0] STD_USED = 32'hfff8_0000;

  // interrupt code values
  localparam logic [3:0] CODE_ERR = 4'h0;

  // identifier image laid out exactly like the high:low mask words
  typedef struct packed {
    logic [10:0] id_hi;   // id 28..18 (standard id 10..0)
    logic rtr_srr;        // standard rtr / extended srr
    logic ide;
    logic [2:0] id_mid;   // id 17..15
    logic [14:0] id_lo;   // id 14..0
    logic ext_remote_req_mask;           // extended rtr
  } camis_frame_type;

  // one acceptance query from the frame engine
  typedef struct packed {
    logic req;
    logic buf14;          // target is buffer 14
    camis_frame_type rx;  // received identifier
    camis_frame_type held; // buffer identifier
  } camis_accept_type;

  // events and counters from the error management logic
  typedef struct packed {
    logic bus_error;      // one-cycle pulse per bus error
    logic cnt_inc;        // pulse: rec or tec incremented
    logic [2:0] node_state;
    logic [7:0] rec;
    logic [7:0] tec;
  } camis_err_type;

endpackage

//--- camis_regs.sv
// camis_regs: wishbone register slave holding both acceptance masks,
// the acceptance compare, interrupt enable/pending/clear/code logic,
// node status and error counter readback.
// assumes frame engine and error logic run on clk_sys; their pulses
// last one cycle.
`timescale 1ns/10ps

module camis_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // acceptance query and answer
  input wire camis_pkg::camis_accept_type acc_i,
  output logic acc_valid_o,
  output logic acc_hit_o,
  output camis_pkg::camis_frame_type acc_id_o,
  // message buffer completion pulses, bit n for buffer n
  input wire logic [14:0] buf_done_i,
  // error management logic
  input wire camis_pkg::camis_err_type err_i,
  // interrupt request to the cpu
  output logic can_irq_o
);

  // registers
  logic [15:0] gmask_hi_ff, gmask_lo_ff, bmask_hi_ff, bmask_lo_ff;
  logic [15:0] irq_en_ff, pend_ff, code_en_ff;
  logic err_type_ff;
  logic [2:0] ns_ff;
  logic [7:0] rec_ff, tec_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic acc_valid_ff, acc_hit_ff, irq_ff;
  camis_pkg::camis_frame_type acc_id_ff;

  // byte-lane write merge for a 16-bit register
  function automatic logic [15:0] lane_wr(input logic [15:0] old,
                                          input logic [15:0] d,
                                          input logic [1:0] sel);
    logic [15:0] bm;
    bm = {{8{sel[1]}}, {8{sel[0]}}};
    lane_wr = (old & ~bm) | (d & bm);
  endfunction

  // effective mask: standard frames never use the low mask bits
  function automatic logic [31:0] eff_mask(input logic [31:0] m,
                                           input logic ide);
    eff_mask = ide ? m : (m & camis_pkg::STD_USED);
  endfunction

  // bits that take part in the compare for this frame format
  function automatic logic [31:0] used_bits(input logic ide);
    used_bits = ide ? 32'hffff_ffff : camis_pkg::STD_USED;
  endfunction

  // highest-priority code-enabled source: {request, code}
  function automatic logic [4:0] prio(input logic [15:0] act);
    logic [4:0] r;
    r = 5'h00;
    for (int n = camis_pkg::NUM_BUF - 1; n >= 0; n--) begin
      if (act[n]) begin
        r = {1'b1, 4'(n + 1)};
      end
    end
    if (act[camis_pkg::ERR_BIT]) begin
      r = {1'b1, camis_pkg::CODE_ERR};
    end
    prio = r;
  endfunction

  // bus decode
  wire req_w = wb_cyc_i & wb_stb_i;
  wire rd_take = req_w & ~ack_ff;
  wire wr_take = req_w & wb_we_i & ack_ff;
  wire [7:0] adr_w = 8'(wb_adr_i);
  wire [1:0] sel_w = wb_sel_i[1:0];
  wire [15:0] wd_w = wb_dat_i[15:0];
  wire wr_gmh = wr_take & (adr_w == camis_pkg::OFF_GMASK_HI);
  wire wr_gml = wr_take & (adr_w == camis_pkg::OFF_GMASK_LO);
  wire wr_bmh = wr_take & (adr_w == camis_pkg::OFF_BMASK_HI);
  wire wr_bml = wr_take & (adr_w == camis_pkg::OFF_BMASK_LO);
  wire wr_ien = wr_take & (adr_w == camis_pkg::OFF_IRQ_EN);
  wire wr_clr = wr_take & (adr_w == camis_pkg::OFF_IRQ_CLR);
  wire wr_cen = wr_take & (adr_w == camis_pkg::OFF_CODE_EN);
  wire wr_cfg = wr_take & (adr_w == camis_pkg::OFF_ERR_CFG);

  // acceptance compare, global or buffer 14 mask pair
  wire [31:0] gmask_w = {gmask_hi_ff, gmask_lo_ff};
  wire [31:0] bmask_w = {bmask_hi_ff, bmask_lo_ff};
  wire [31:0] sel_mask_w = acc_i.buf14 ? bmask_w : gmask_w;
  wire [31:0] rx_w = acc_i.rx;
  wire [31:0] held_w = acc_i.held;
  // rx bit positions already follow the mask layout
  wire [31:0] em_w = eff_mask(sel_mask_w, acc_i.rx.ide);
  wire [31:0] care_w = used_bits(acc_i.rx.ide) & ~em_w;
  wire hit_w = ((rx_w ^ held_w) & care_w) == 32'h0000_0000;
  wire [31:0] merged_w = (held_w & ~em_w) | (rx_w & em_w);

  // error pending set source
  wire ns_chg_w = err_i.node_state != ns_ff;
  wire err_set_w = err_type_ff ? (err_i.cnt_inc & ns_chg_w)
                               : err_i.bus_error;
  wire [15:0] set_w = {err_set_w, buf_done_i};
  wire [15:0] clr_w = wr_clr ? lane_wr(16'h0000, wd_w, sel_w)
                             : 16'h0000;
  // set wins over clear
  wire [15:0] nxt_pend = (pend_ff & ~clr_w) | set_w;

  // interrupt code and request
  wire [4:0] code_w = prio(pend_ff & code_en_ff);
  wire nxt_irq = |(pend_ff & irq_en_ff);
  wire [15:0] status_w = {8'h00, ns_ff, code_w};

  // read data selection; clear register and holes read zero
  wire [15:0] rd_w =
    (adr_w == camis_pkg::OFF_GMASK_HI) ? gmask_hi_ff :
    (adr_w == camis_pkg::OFF_GMASK_LO) ? gmask_lo_ff :
    (adr_w == camis_pkg::OFF_BMASK_HI) ? bmask_hi_ff :
    (adr_w == camis_pkg::OFF_BMASK_LO) ? bmask_lo_ff :
    (adr_w == camis_pkg::OFF_IRQ_EN) ? irq_en_ff :
    (adr_w == camis_pkg::OFF_IRQ_PEND) ? pend_ff :
    (adr_w == camis_pkg::OFF_CODE_EN) ? code_en_ff :
    (adr_w == camis_pkg::OFF_STATUS) ? status_w :
    (adr_w == camis_pkg::OFF_ERR_CNT) ? {rec_ff, tec_ff} :
    (adr_w == camis_pkg::OFF_ERR_CFG) ? {15'h0000, err_type_ff} :
    16'h0000;

  // bus handshake: ack one cycle after the request, data with it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= rd_take;
      if (rd_take) begin
        dat_ff <= {16'h0000, rd_w};
      end
    end
  end

  // mask registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gmask_hi_ff <= camis_pkg::RST_MASK;
      gmask_lo_ff <= camis_pkg::RST_MASK;
      bmask_hi_ff <= camis_pkg::RST_MASK;
      bmask_lo_ff <= camis_pkg::RST_MASK;
    end else begin
      if (wr_gmh) gmask_hi_ff <= lane_wr(gmask_hi_ff, wd_w, sel_w);
      if (wr_gml) gmask_lo_ff <= lane_wr(gmask_lo_ff, wd_w, sel_w);
      if (wr_bmh) bmask_hi_ff <= lane_wr(bmask_hi_ff, wd_w, sel_w);
      if (wr_bml) bmask_lo_ff <= lane_wr(bmask_lo_ff, wd_w, sel_w);
    end
  end

  // interrupt control registers and pending flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_en_ff <= camis_pkg::RST_IRQ;
      code_en_ff <= camis_pkg::RST_IRQ;
      err_type_ff <= camis_pkg::RST_ERR_TYPE;
      pend_ff <= camis_pkg::RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ien) irq_en_ff <= lane_wr(irq_en_ff, wd_w, sel_w);
      if (wr_cen) code_en_ff <= lane_wr(code_en_ff, wd_w, sel_w);
      if (wr_cfg && sel_w[0]) err_type_ff <= wd_w[camis_pkg::CFG_TYPE_BIT];
      pend_ff <= nxt_pend;
      irq_ff <= nxt_irq;
    end
  end

  // node state and counter capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ns_ff <= 3'h0;
      rec_ff <= 8'h00;
      tec_ff <= 8'h00;
    end else begin
      ns_ff <= err_i.node_state;
      rec_ff <= err_i.rec;
      tec_ff <= err_i.tec;
    end
  end

  // acceptance answer, one cycle after the query
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_valid_ff <= 1'b0;
      acc_hit_ff <= 1'b0;
      acc_id_ff <= '0;
    end else begin
      acc_valid_ff <= acc_i.req;
      if (acc_i.req) begin
        acc_hit_ff <= hit_w;
        acc_id_ff <= hit_w ? merged_w : held_w;
      end
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign acc_valid_o = acc_valid_ff;
  assign acc_hit_o = acc_hit_ff;
  assign acc_id_o = acc_id_ff;
  assign can_irq_o = irq_ff;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // check helpers: bits set and cleared together, bits left alone
  wire [15:0] both_w = clr_w & set_w;
  wire [15:0] keep_w = pend_ff & ~clr_w;

  a_ack_one_cycle: assert property (
    rd_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  a_buf_set_wins: assert property (
    (buf_done_i != 15'h0000) |=>
      ((pend_ff[14:0] & $past(buf_done_i)) == $past(buf_done_i)))
    else $error("buffer pending not set after done");
  a_clear_no_set: assert property (
    (wr_clr && set_w == 16'h0000) |=>
      ((pend_ff & $past(clr_w)) == 16'h0000))
    else $error("pending bit survived clear");
  a_set_beats_clr: assert property (
    (wr_clr && both_w != 16'h0000) |=>
      ((pend_ff & $past(both_w)) == $past(both_w)))
    else $error("clear won over simultaneous set");
  a_err_first: assert property (
    (pend_ff[15] && code_en_ff[15]) |-> (code_w == 5'h10))
    else $error("error source not reported first");
  a_code_buffer: assert property (
    (pend_ff[15:1] & code_en_ff[15:1]) == 15'h0000 &&
      pend_ff[0] && code_en_ff[0] |-> (code_w == 5'h11))
    else $error("buffer 0 code wrong");
  a_irq_gated: assert property (
    ((pend_ff & irq_en_ff) == 16'h0000) |=> !can_irq_o)
    else $error("interrupt without enabled pending source");
  a_err_irq: assert property (
    (err_set_w && irq_en_ff[15] && !wr_ien) |=> ##1 can_irq_o)
    else $error("error interrupt not raised");
  a_type0_err: assert property (
    (!err_type_ff && err_i.bus_error) |=> pend_ff[15])
    else $error("bus error did not set error pending");
  a_type1_quiet: assert property (
    (err_type_ff && !err_i.cnt_inc && !pend_ff[15] && !wr_cfg)
      |=> !pend_ff[15])
    else $error("error pending set without counter step");
  a_exact_hit: assert property (
    (acc_i.req && acc_i.rx == acc_i.held) |=> acc_valid_o && acc_hit_o)
    else $error("identical identifier rejected");
  a_std_low_free: assert property (
    (acc_i.req && !acc_i.rx.ide &&
      (((rx_w ^ held_w) & camis_pkg::STD_USED) == 32'h0000_0000))
      |=> acc_hit_o)
    else $error("standard frame used low mask bits");
  a_dontcare_copy: assert property (
    (acc_i.req && acc_i.rx.ide && sel_mask_w == 32'hffff_ffff)
      |=> acc_hit_o && (acc_id_o == $past(rx_w)))
    else $error("full mask did not copy received id");
  a_status_rsvd: assert property (
    (rd_take && adr_w == camis_pkg::OFF_STATUS) |=>
      (wb_dat_o[31:8] == 24'h00_0000) &&
      (wb_dat_o[7:5] == $past(err_i.node_state, 2)))
    else $error("status reserved bits or node state wrong");

  // bus readback and write checks
  a_clr_reads_zero: assert property (
    (rd_take && adr_w == camis_pkg::OFF_IRQ_CLR) |=>
      (wb_dat_o == 32'h0000_0000))
    else $error("clear register did not read zero");
  a_cnt_readback: assert property (
    (rd_take && adr_w == camis_pkg::OFF_ERR_CNT) |=>
      (wb_dat_o == {16'h0000, $past(err_i.rec, 2), $past(err_i.tec, 2)}))
    else $error("error counters read back wrong");
  a_code_idle: assert property (
    (rd_take && adr_w == camis_pkg::OFF_STATUS &&
      (pend_ff & code_en_ff) == 16'h0000) |=> (wb_dat_o[4:0] == 5'h00))
    else $error("code shown without enabled pending source");
  a_mask_write: assert property (
    (wr_gmh && sel_w == 2'b11) |=> (gmask_hi_ff == $past(wd_w)))
    else $error("global mask high word not written");
  a_ien_write: assert property (
    (wr_ien && sel_w == 2'b11) |=> (irq_en_ff == $past(wd_w)))
    else $error("interrupt enable not written");

  // pending flag checks
  a_pend_keep: assert property (
    1'b1 |=> ((pend_ff & $past(keep_w)) == $past(keep_w)))
    else $error("pending bit lost without a clear");
  a_type1_set: assert property (
    (err_type_ff && err_i.cnt_inc &&
      err_i.node_state != $past(err_i.node_state)) |=> pend_ff[15])
    else $error("state change on counter step did not set error");

  // acceptance checks
  a_valid_pulse: assert property (
    1'b1 |=> (acc_valid_o == $past(acc_i.req)))
    else $error("acceptance answer not one cycle after query");
  a_ext_miss: assert property (
    (acc_i.req && acc_i.rx.ide &&
      ((rx_w ^ held_w) & ~sel_mask_w) != 32'h0000_0000) |=> !acc_hit_o)
    else $error("extended frame accepted with unmasked mismatch");
  a_std_miss: assert property (
    (acc_i.req && !acc_i.rx.ide && ((rx_w ^ held_w) & ~sel_mask_w &
      camis_pkg::STD_USED) != 32'h0000_0000) |=> !acc_hit_o)
    else $error("standard frame accepted with unmasked mismatch");
  a_std_keep_low: assert property (
    (acc_i.req && !acc_i.rx.ide) |=>
      (((acc_id_o ^ $past(held_w)) & ~camis_pkg::STD_USED) ==
        32'h0000_0000))
    else $error("standard frame changed unused identifier bits");
  a_b14_own_mask: assert property (
    (acc_i.req && acc_i.buf14 &&
      ((rx_w ^ held_w) & ~bmask_w) == 32'h0000_0000) |=> acc_hit_o)
    else $error("buffer 14 query not filtered by its own mask");

  c_hit_b14: cover property (acc_i.req && acc_i.buf14 ##1 acc_hit_o);
  c_irq: cover property (!can_irq_o ##1 can_irq_o);
  c_set_clr: cover property (wr_clr && (clr_w & set_w) != 16'h0000);
  c_err_code: cover property (code_w == 5'h10);
  c_type1_set: cover property (err_type_ff && err_set_w);

endmodule

//--- can_accept_mask_irq_status_tb.sv
// can_accept_mask_irq_status_tb: self-checking bench for camis_regs.
// assumes camis_far stands in for the frame engine and error logic.
`timescale 1ns/10ps
module can_accept_mask_irq_status_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, valid, hit, irq;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'h3;
  logic [31:0] wdat = 32'h0, rdat, gm, bm, rx, hd, m;
  logic [32:0] x;
  logic [15:0] q, en, ce, r16;
  logic [14:0] done;
  logic b;
  camis_pkg::camis_accept_type acc;
  camis_pkg::camis_frame_type acc_id;
  camis_pkg::camis_err_type err;
  logic [7:0] ro[5] = '{8'h14, 8'h18, 8'h20, 8'h24, 8'h2c};
  logic [7:0] rw[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
  logic [2:0] nsl[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
  int fails = 0, n_checks = 0;

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  camis_regs u_camis_regs (.clk_sys(clk_sys), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .acc_i(acc), .acc_valid_o(valid), .acc_hit_o(hit),
    .acc_id_o(acc_id), .buf_done_i(done), .err_i(err),
    .can_irq_o(irq));
  camis_far u_camis_far (.clk_sys(clk_sys), .acc_o(acc), .done_o(done),
    .err_o(err));

  // value compare
  task automatic chk(input string s, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // one classic wishbone cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [15:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, lanes, 16'h0, d};
    do begin
      @(posedge clk_sys);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t == 20) fails++;
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
    input string s);
    wb(1'b0, a, 16'h0);
    chk(s, {16'h0, e}, {16'h0, q});
  endtask
  // expected {hit, stored id} of one acceptance query
  function automatic logic [32:0] exp_acc(logic [31:0] mk, r, h);
    logic [31:0] u;
    u = r[19] ? 32'hffff_ffff : camis_pkg::STD_USED;
    mk = mk & u;
    if (((r ^ h) & u & ~mk) != 32'h0) return {1'b0, h};
    return {1'b1, (h & ~mk) | (r & mk)};
  endfunction
  // expected {request, code} for pending and code-enable words
  function automatic logic [4:0] exp_code(logic [15:0] p, c);
    logic [15:0] a;
    a = p & c;
    if (a[15]) return 5'h10;
    for (int i = 0; i < 15; i++) if (a[i]) return 5'(i + 17);
    return 5'h00;
  endfunction
  task automatic pulse(input logic [14:0] v);
    @(posedge clk_sys);
    u_camis_far.setd(v);
    @(posedge clk_sys);
    u_camis_far.setd(15'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish;
  end

  // main sequence
  initial begin
    void'($urandom(32'h319b));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 0; a < 12; a++) rd(8'(a * 4), 16'h0, "reset");
    foreach (ro[i]) begin
      wr(ro[i], 16'hffff);
      rd(ro[i], 16'h0, "read-only");
    end
    foreach (rw[i]) begin
      r16 = $urandom;
      wr(rw[i], r16);
      rd(rw[i], r16, "rw");
    end
    // byte lanes: each lane lands on its own half of the word
    wr(8'h00, 16'h0000);
    lanes = 4'h1;
    wr(8'h00, 16'hffff);
    lanes = 4'h2;
    wr(8'h00, 16'h5a5a);
    lanes = 4'h3;
    rd(8'h00, 16'h5aff, "byte lanes");
    $display("test registers done");
    repeat (40) begin
      gm = $urandom | $urandom;
      bm = $urandom | $urandom;
      rx = $urandom;
      hd = rx ^ ($urandom & $urandom & $urandom);
      b = 1'($urandom_range(1));
      wr(8'h00, gm[31:16]);
      wr(8'h04, gm[15:0]);
      wr(8'h08, bm[31:16]);
      wr(8'h0c, bm[15:0]);
      u_camis_far.query(b, rx, hd);
      @(posedge clk_sys);
      x = exp_acc(b ? bm : gm, rx, hd);
      chk("acc_valid", 32'h1, {31'h0, valid});
      chk("acc_hit", {31'h0, x[32]}, {31'h0, hit});
      chk("acc_id", x[31:0], acc_id);
    end
    // corner cases: full global mask on an extended frame, exact match
    rx = $urandom | 32'h0008_0000;
    hd = ~rx;
    wr(8'h00, 16'hffff);
    wr(8'h04, 16'hffff);
    for (int k = 0; k < 2; k++) begin
      u_camis_far.query(1'(k), k ? hd : rx, hd);
      @(posedge clk_sys);
      x = exp_acc(k ? bm : 32'hffff_ffff, k ? hd : rx, hd);
      chk("corner hit", {31'h0, x[32]}, {31'h0, hit});
      chk("corner id", x[31:0], acc_id);
    end
    $display("test acceptance done");
    en = $urandom;
    wr(8'h10, en);
    wr(8'h1c, 16'hffff);
    for (int n = 0; n < 15; n++) begin
      pulse(15'(1 << n));
      repeat (2) @(posedge clk_sys);
      chk("irq", {31'h0, en[n]}, {31'h0, irq});
      rd(8'h14, 16'(1 << n), "pending");
      rd(8'h20, {11'h0, 5'(n + 17)}, "code");
      wr(8'h18, ~16'(1 << n));
      rd(8'h14, 16'(1 << n), "clear zero");
      wr(8'h18, 16'(1 << n));
      rd(8'h14, 16'h0, "clear one");
    end
    u_camis_far.err(1'b1, 1'b0, 3'h0, 8'h0, 8'h0);
    repeat (2) @(posedge clk_sys);
    chk("err irq", {31'h0, en[15]}, {31'h0, irq});
    rd(8'h14, 16'h8000, "err pending");
    rd(8'h20, 16'h0010, "err code");
    wr(8'h18, 16'h8000);
    rd(8'h14, 16'h0, "err clear");
    wr(8'h28, 16'h0001);
    u_camis_far.err(1'b1, 1'b0, 3'h0, 8'h0, 8'h0);
    u_camis_far.err(1'b0, 1'b1, 3'h0, 8'h1, 8'h0);
    rd(8'h14, 16'h0, "type1 no change");
    u_camis_far.err(1'b0, 1'b1, 3'h2, 8'h2, 8'h0);
    rd(8'h14, 16'h8000, "type1 change");
    wr(8'h18, 16'h8000);
    wr(8'h28, 16'h0000);
    $display("test pending done");
    repeat (8) begin
      ce = $urandom;
      m = $urandom;
      wr(8'h1c, ce);
      pulse(m[14:0]);
      if (m[15]) u_camis_far.err(1'b1, 1'b0, 3'h2, 8'h2, 8'h0);
      rd(8'h14, m[15:0], "multi pending");
      rd(8'h20, {8'h0, 3'h2, exp_code(m[15:0], ce)}, "prio");
      wr(8'h18, 16'hffff);
    end
    @(posedge clk_sys);
    u_camis_far.setd(15'h0020);
    wr(8'h18, 16'h0020);
    u_camis_far.setd(15'h0);
    rd(8'h14, 16'h0020, "set beats clear");
    wr(8'h18, 16'hffff);
    $display("test priority done");
    foreach (nsl[i]) begin
      r16 = $urandom;
      u_camis_far.err(1'b0, 1'b0, nsl[i], r16[15:8], r16[7:0]);
      rd(8'h20, {8'h0, nsl[i], 5'h0}, "node state");
      rd(8'h24, r16, "counters");
    end
    $display("test status done");
    tally_and_finish;
  end
endmodule
